// [verilog/carrier_rate_pkg.sv]
package carrier_rate_pkg;

  // Register addresses
  localparam logic [5:0] ADDR_CARRIER_HIGH = 6'h0d;
  localparam logic [5:0] ADDR_CARRIER_MIDDLE = 6'h0e;
  localparam logic [5:0] ADDR_CARRIER_LOW = 6'h0f;
  localparam logic [5:0] ADDR_RATE_EXPONENT = 6'h10;
  localparam logic [5:0] ADDR_RATE_MANTISSA = 6'h11;

  // Reset values
  localparam logic [5:0] RESET_CARRIER_HIGH = 6'h1e;
  localparam logic [7:0] RESET_CARRIER_MIDDLE = 8'hc4;
  localparam logic [7:0] RESET_CARRIER_LOW = 8'hec;
  localparam logic [3:0] RESET_RATE_EXPONENT = 4'hc;
  localparam logic [7:0] RESET_RATE_MANTISSA = 8'h22;

  // Field widths
  localparam int CARRIER_HIGH_W = 6;
  localparam int CARRIER_WORD_W = 24;
  localparam int EXPONENT_W = 4;
  localparam int MANTISSA_W = 8;
  localparam int SPACING_W = 16;
  localparam int PHASE_W = 28;
  localparam int INCREMENT_W = 24;

  // Hidden leading one of the mantissa, value 256
  localparam logic [INCREMENT_W-1:0] MANTISSA_HIDDEN_ONE = 24'h00_0100;
  localparam logic [7:0] READ_ZERO = 8'h00;

  typedef struct packed {
    logic [CARRIER_HIGH_W-1:0] high;
    logic [7:0] middle;
    logic [7:0] low;
  } carrier_cfg_t;

  typedef struct packed {
    logic [EXPONENT_W-1:0] exponent;
    logic [MANTISSA_W-1:0] mantissa;
  } rate_cfg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage : carrier_rate_pkg

// [verilog/symbol_rate_accumulator.sv]
`timescale 1ns/100ps
module symbol_rate_accumulator (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire carrier_rate_pkg::rate_cfg_t rate_in,
  output logic symbol_strobe_out
);

  logic [carrier_rate_pkg::PHASE_W-1:0] phase_reg;
  logic [carrier_rate_pkg::INCREMENT_W-1:0] increment;
  logic [carrier_rate_pkg::PHASE_W:0] sum;

  // (256 + mantissa) shifted by exponent
  assign increment = (carrier_rate_pkg::MANTISSA_HIDDEN_ONE
                      | carrier_rate_pkg::INCREMENT_W'(rate_in.mantissa)) << rate_in.exponent;
  assign sum = {1'b0, phase_reg} + (carrier_rate_pkg::PHASE_W + 1)'(increment);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      phase_reg <= '0;
    end else begin
      phase_reg <= sum[carrier_rate_pkg::PHASE_W-1:0];
    end
  end

  // Strobe on every overflow of the 28-bit phase
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      symbol_strobe_out <= 1'b0;
    end else begin
      symbol_strobe_out <= sum[carrier_rate_pkg::PHASE_W];
    end
  end

endmodule : symbol_rate_accumulator

// [verilog/carrier_and_symbol_rate_config.sv]
`timescale 1ns/100ps
// Function
// - Top two bits of the high carrier register read zero and ignore writes.
// - Carrier word is high[5:0], middle and low bytes concatenated.
// - Carrier frequency equals carrier word times oscillator over 2^16.
// - Rate exponent is a 4-bit field in bits 3:0 of its register.
// - Symbol rate uses 4-bit exponent and 8-bit mantissa with hidden one.
// - Rate is (256 + mantissa) times 2^exponent over 2^28 times oscillator.
// - Bits 7:4 of the exponent register read back as zero.
// - Synth word adds channel number times channel spacing to the base word.
module carrier_and_symbol_rate_config (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] channel_number_in,
  input wire logic [carrier_rate_pkg::SPACING_W-1:0] channel_spacing_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic [carrier_rate_pkg::CARRIER_WORD_W-1:0] carrier_word_out,
  output logic [carrier_rate_pkg::CARRIER_WORD_W-1:0] synth_word_out,
  output logic symbol_strobe_out
);

  // Request bundle from the register port
  carrier_rate_pkg::reg_req_t req;

  // Stored register fields
  logic [carrier_rate_pkg::CARRIER_HIGH_W-1:0] carrier_high_reg;
  logic [7:0] carrier_middle_reg;
  logic [7:0] carrier_low_reg;
  logic [carrier_rate_pkg::EXPONENT_W-1:0] rate_exponent_reg;
  logic [carrier_rate_pkg::MANTISSA_W-1:0] rate_mantissa_reg;

  // Field bundles
  carrier_rate_pkg::carrier_cfg_t carrier_cfg;
  carrier_rate_pkg::rate_cfg_t rate_cfg;

  // Write selects
  logic write_high;
  logic write_middle;
  logic write_low;
  logic write_exponent;
  logic write_mantissa;

  // Data words
  logic [7:0] read_value;
  logic [carrier_rate_pkg::CARRIER_WORD_W-1:0] carrier_word;
  logic [carrier_rate_pkg::CARRIER_WORD_W-1:0] channel_offset;
  logic [carrier_rate_pkg::CARRIER_WORD_W-1:0] synth_word;

  // Write select for one register address
  function automatic logic write_hit(input carrier_rate_pkg::reg_req_t r,
                                     input logic [5:0] addr);
    logic hit;
    hit = r.wr && (r.addr == addr);
    return hit;
  endfunction : write_hit

  // Read value of one register, reserved bits as zero
  function automatic logic [7:0] read_mux(input logic [5:0] addr,
                                          input carrier_rate_pkg::carrier_cfg_t c,
                                          input carrier_rate_pkg::rate_cfg_t r);
    logic [7:0] value;
    value = carrier_rate_pkg::READ_ZERO;
    case (addr)
      carrier_rate_pkg::ADDR_CARRIER_HIGH: value = {2'b00, c.high};
      carrier_rate_pkg::ADDR_CARRIER_MIDDLE: value = c.middle;
      carrier_rate_pkg::ADDR_CARRIER_LOW: value = c.low;
      carrier_rate_pkg::ADDR_RATE_EXPONENT: value = {4'h0, r.exponent};
      carrier_rate_pkg::ADDR_RATE_MANTISSA: value = r.mantissa;
      default: value = carrier_rate_pkg::READ_ZERO;
    endcase
    return value;
  endfunction : read_mux

  // Carrier word from its byte fields, top bits zero
  function automatic logic [carrier_rate_pkg::CARRIER_WORD_W-1:0] merge_carrier(
      input carrier_rate_pkg::carrier_cfg_t c);
    logic [carrier_rate_pkg::CARRIER_WORD_W-1:0] word;
    word = {2'b00, c.high, c.middle, c.low};
    return word;
  endfunction : merge_carrier

  // Carrier word held while in reset
  localparam logic [carrier_rate_pkg::CARRIER_WORD_W-1:0] RESET_WORD = merge_carrier(
    carrier_rate_pkg::carrier_cfg_t'{
      high: carrier_rate_pkg::RESET_CARRIER_HIGH,
      middle: carrier_rate_pkg::RESET_CARRIER_MIDDLE,
      low: carrier_rate_pkg::RESET_CARRIER_LOW
    });

  // Register request from the port
  assign req = '{
    wr: reg_wr_in,
    rd: reg_rd_in,
    addr: reg_addr_in,
    wdata: reg_wdata_in
  };

  // Address decode for writes
  assign write_high = write_hit(req, carrier_rate_pkg::ADDR_CARRIER_HIGH);
  assign write_middle = write_hit(req, carrier_rate_pkg::ADDR_CARRIER_MIDDLE);
  assign write_low = write_hit(req, carrier_rate_pkg::ADDR_CARRIER_LOW);
  assign write_exponent = write_hit(req, carrier_rate_pkg::ADDR_RATE_EXPONENT);
  assign write_mantissa = write_hit(req, carrier_rate_pkg::ADDR_RATE_MANTISSA);

  // High carrier byte, bits 7:6 never stored
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      carrier_high_reg <= carrier_rate_pkg::RESET_CARRIER_HIGH;
    end else if (write_high) begin
      carrier_high_reg <= req.wdata[carrier_rate_pkg::CARRIER_HIGH_W-1:0];
    end
  end

  // Middle carrier byte
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      carrier_middle_reg <= carrier_rate_pkg::RESET_CARRIER_MIDDLE;
    end else if (write_middle) begin
      carrier_middle_reg <= req.wdata;
    end
  end

  // Low carrier byte
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      carrier_low_reg <= carrier_rate_pkg::RESET_CARRIER_LOW;
    end else if (write_low) begin
      carrier_low_reg <= req.wdata;
    end
  end

  // Rate exponent, upper nibble never stored
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rate_exponent_reg <= carrier_rate_pkg::RESET_RATE_EXPONENT;
    end else if (write_exponent) begin
      rate_exponent_reg <= req.wdata[carrier_rate_pkg::EXPONENT_W-1:0];
    end
  end

  // Rate mantissa
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rate_mantissa_reg <= carrier_rate_pkg::RESET_RATE_MANTISSA;
    end else if (write_mantissa) begin
      rate_mantissa_reg <= req.wdata;
    end
  end

  // Bundle the stored fields
  assign carrier_cfg = '{
    high: carrier_high_reg,
    middle: carrier_middle_reg,
    low: carrier_low_reg
  };
  assign rate_cfg = '{
    exponent: rate_exponent_reg,
    mantissa: rate_mantissa_reg
  };

  // Read value of the addressed register
  assign read_value = read_mux(req.addr, carrier_cfg, rate_cfg);

  // Read data, loaded one cycle after the strobe and held until the next read
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      reg_rdata_out <= carrier_rate_pkg::READ_ZERO;
    end else if (req.rd) begin
      reg_rdata_out <= read_value;
    end
  end

  // Read valid, one-cycle pulse
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= req.rd;
    end
  end

  // Base carrier word
  assign carrier_word = merge_carrier(carrier_cfg);

  // Channel offset, product kept to the carrier word width
  assign channel_offset = carrier_rate_pkg::CARRIER_WORD_W'(channel_number_in)
                          * carrier_rate_pkg::CARRIER_WORD_W'(channel_spacing_in);
  // Channel-shifted word, wraps at the carrier word width
  assign synth_word = carrier_word + channel_offset;

  // Base word toward the synthesizer, in steps of oscillator / 2^16
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      carrier_word_out <= RESET_WORD;
    end else begin
      carrier_word_out <= carrier_word;
    end
  end

  // Channel-shifted word toward the synthesizer
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      synth_word_out <= RESET_WORD;
    end else begin
      synth_word_out <= synth_word;
    end
  end

  // Symbol strobe generator
  symbol_rate_accumulator rate_gen (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .rate_in(rate_cfg),
    .symbol_strobe_out(symbol_strobe_out)
  );

endmodule : carrier_and_symbol_rate_config

// [bench/rate_cfg_assertions.sv]
`timescale 1ns/100ps
module rate_cfg_checker (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] channel_number_in,
  input wire logic [15:0] channel_spacing_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic [23:0] carrier_word_out,
  input wire logic [23:0] synth_word_out,
  input wire logic symbol_strobe_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_wr_exp;
    reg_wr_in && reg_addr_in == 6'h10 ##1 reg_rd_in && reg_addr_in == 6'h10;
  endsequence
  property p_top; carrier_word_out[23:22] == 2'b00; endproperty
  a_top: assert property (p_top) else $error("carrier top bits set");
  property p_hi_rd; reg_rd_in && reg_addr_in == 6'h0d |=> reg_rdata_out[7:6] == 2'b00; endproperty
  a_hi_rd: assert property (p_hi_rd) else $error("high byte top bits read");
  property p_mid; reg_wr_in && reg_addr_in == 6'h0e |-> ##2 carrier_word_out[15:8] == $past(reg_wdata_in, 2); endproperty
  a_mid: assert property (p_mid) else $error("middle byte wrong");
  property p_low; reg_wr_in && reg_addr_in == 6'h0f |-> ##2 carrier_word_out[7:0] == $past(reg_wdata_in, 2); endproperty
  a_low: assert property (p_low) else $error("low byte wrong");
  property p_exp; s_wr_exp |=> reg_rdata_out == {4'h0, 4'($past(reg_wdata_in, 2))}; endproperty
  a_exp: assert property (p_exp) else $error("exponent readback wrong");
  property p_res; reg_rd_in && reg_addr_in == 6'h10 |=> reg_rdata_out[7:4] == 4'h0; endproperty
  a_res: assert property (p_res) else $error("reserved bits set");
  property p_synth; !$past(reset_in) |-> synth_word_out == carrier_word_out
    + 24'($past(channel_number_in)) * 24'($past(channel_spacing_in)); endproperty
  a_synth: assert property (p_synth) else $error("synth word wrong");
  property p_pulse; symbol_strobe_out |=> !symbol_strobe_out; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe too long");
  property p_first; $fell(reset_in) |-> ##226 symbol_strobe_out; endproperty
  a_first: assert property (p_first) else $error("first strobe late");
endmodule : rate_cfg_checker
bind carrier_and_symbol_rate_config rate_cfg_checker i_rate_cfg_checker (.*);

// [bench/reg_host.sv]
`timescale 1ns/100ps
module reg_host (
  input wire logic clk_in,
  output carrier_rate_pkg::reg_req_t req_out
);
  initial req_out = '0;
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1 req_out = {2'b10, a, d};
  endtask : wr_reg
  task automatic rd_reg(input logic [5:0] a);
    @(posedge clk_in);
    #1 req_out = {2'b01, a, ~req_out.wdata};
  endtask : rd_reg
  task automatic idle();
    @(posedge clk_in);
    #1 req_out = {2'b00, ~req_out.addr, ~req_out.wdata};
  endtask : idle
endmodule : reg_host

// [bench/tb_carrier_and_symbol_rate_config.sv]
`timescale 1ns/100ps
module tb_carrier_and_symbol_rate_config;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] channel_number = 8'h00;
  logic [15:0] spacing = 16'h0000;
  logic [7:0] rdata;
  logic rvalid, strobe;
  logic [23:0] cw, sw;
  carrier_rate_pkg::reg_req_t req;
  int err_total = 0;
  int tests_run = 0;
  int n;
  always #4 clk_in = ~clk_in;
  reg_host i_reg_host (.clk_in(clk_in), .req_out(req));
  carrier_and_symbol_rate_config i_carrier_and_symbol_rate_config (.clk_in(clk_in), .reset_in(reset_in),
    .reg_wr_in(req.wr), .reg_rd_in(req.rd), .reg_addr_in(req.addr), .reg_wdata_in(req.wdata),
    .channel_number_in(channel_number), .channel_spacing_in(spacing), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .carrier_word_out(cw), .synth_word_out(sw), .symbol_strobe_out(strobe));
  task chk(input string s, input logic [23:0] e, input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task rdchk(input logic [5:0] a, input logic [7:0] e);
    i_reg_host.rd_reg(a);
    i_reg_host.idle();
    chk("rdata", {16'h0000, e}, {16'h0000, rdata});
    chk("rvalid", 24'h00_0001, {23'h00_0000, rvalid});
    i_reg_host.idle();
    chk("rvalid", 24'h00_0000, {23'h00_0000, rvalid});
  endtask : rdchk
  task t_reset();
    rdchk(6'h0d, 8'h1e);
    rdchk(6'h0e, 8'hc4);
    rdchk(6'h0f, 8'hec);
    rdchk(6'h10, 8'h0c);
    rdchk(6'h11, 8'h22);
    chk("carrier", 24'h1e_c4ec, cw);
    repeat (230) @(posedge clk_in);
    $display("reset test done");
  endtask : t_reset
  task t_write();
    i_reg_host.wr_reg(6'h0d, 8'hff);
    i_reg_host.wr_reg(6'h0e, 8'h55);
    i_reg_host.wr_reg(6'h0f, 8'haa);
    i_reg_host.wr_reg(6'h20, 8'h77);
    rdchk(6'h0d, 8'h3f);
    rdchk(6'h20, 8'h00);
    chk("carrier", 24'h3f_55aa, cw);
    $display("write test done");
  endtask : t_write
  task t_rate();
    i_reg_host.wr_reg(6'h11, 8'h00);
    i_reg_host.wr_reg(6'h10, 8'hff);
    rdchk(6'h10, 8'h0f);
    n = 0;
    while (strobe !== 1'b1 && n < 100) begin
      @(posedge clk_in);
      #1 n++;
    end
    n = 0;
    do begin
      @(posedge clk_in);
      #1 n++;
    end while (strobe !== 1'b1 && n < 100);
    chk("period", 24'h00_0020, 24'(n));
    $display("rate test done");
  endtask : t_rate
  task t_synth();
    channel_number = 8'h03;
    spacing = 16'h0100;
    repeat (2) @(posedge clk_in);
    #1 chk("synth", 24'h3f_58aa, sw);
    channel_number = 8'hff;
    spacing = 16'hffff;
    repeat (2) @(posedge clk_in);
    #1 chk("synth", 24'h3e_54ab, sw);
    $display("synth test done");
  endtask : t_synth
  task print_verdict();
    $display("tests %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    #24000 err_total++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clk_in);
    #1 reset_in = 1'b0;
    t_reset();
    t_write();
    t_rate();
    t_synth();
    print_verdict();
  end
endmodule : tb_carrier_and_symbol_rate_config
